//--- etp_pkg.sv
// Shared constants for the emulator target probe control block
package etp_pkg;
   // Register byte offsets
   localparam logic [7:0] ETP_CTRL_OFF = 8'h00;
   localparam logic [7:0] ETP_STAT_OFF = 8'h04;
   localparam logic [7:0] ETP_BKPT_OFF = 8'h08;
   localparam logic [7:0] ETP_EVPT_OFF = 8'h0c;
   localparam logic [7:0] ETP_MAP_OFF = 8'h10;
   localparam logic [7:0] ETP_ISTAT_OFF = 8'h14;
   localparam logic [7:0] ETP_IMASK_OFF = 8'h18;
   // Control fields
   localparam int ETP_CTRL_GO = 0;
   localparam int ETP_CTRL_HALT = 1;
   localparam int ETP_CTRL_SEL_LSB = 2;
   localparam int ETP_CTRL_MODE1 = 6;
   // Select fields within the 4-bit select setting
   localparam int ETP_SEL_DATA = 0;
   localparam int ETP_SEL_RD_PASS = 1;
   localparam int ETP_SEL_RD_SUPP = 2;
   localparam int ETP_SEL_WAIT = 3;
   localparam logic [3:0] ETP_SEL_RST = 4'h3;
   localparam logic ETP_MODE1_RST = 1'b1;
   // Address compare enable bit in breakpoint and event registers
   localparam int ETP_PT_EN = 16;
   localparam logic [15:0] ETP_MAP_RST = 16'h0000;
   // Interrupt status bits
   localparam int ETP_IRQ_EXT = 0;
   localparam int ETP_IRQ_BKPT = 1;
   localparam int ETP_IRQ_EVT = 2;
   localparam int ETP_IRQ_HALTREQ = 3;
   localparam int ETP_IRQ_W = 4;
   // Strap value used when the strap pins read zero
   localparam logic [1:0] ETP_WAIT_DEF = 2'h2;
   // Event trigger low pulse width
   localparam int ETP_CLK_MHZ = 25;
   localparam int ETP_EVT_LOW_NS = 200;
   localparam int ETP_EVT_CYC = (ETP_EVT_LOW_NS * ETP_CLK_MHZ + 999) / 1000;
   // Return-from-interrupt opcode bytes
   localparam logic [7:0] ETP_INTERRUPT_RETURN_OPCODE_B0 = 8'hed;
   localparam logic [7:0] ETP_INTERRUPT_RETURN_OPCODE_B1 = 8'h4d;
   // Emulation state
   typedef enum logic {ETP_HALTED, ETP_RUNNING} etp_state_t;
endpackage : etp_pkg

//--- etp_probe_ctrl.sv
// Target-side probe, select and wait-state control of an emulator pod
//
// Notes on behaviour
// - emulation-active output high while running user code, low when halted.
// - event-trigger output pulses low when an enabled event point is fetched.
// - map-control input low forces every address to target memory.
// - external-break input low during emulation halts execution.
// - auxiliary header drives the interrupt-return opcode onto the buffered target bus while select bit 1 is off.
// - select bit 1 gates the eight emulator data lines onto the target bus.
// - select bits 2 and 3 together pass or suppress the read strobe.
// - select bit 4 inserts one to three strapped wait clocks per cycle.
// - bit 1 on drives data lines out; off leaves them disconnected.
// - bit 2 on, bit 3 off passes read strobe regardless of map.
// - bit 2 off, bit 3 on withholds read strobe on emulation-memory fetch, mode one; the code withholds it on any emulation-memory request.
// - bit 4 on adds strapped waits each cycle; off adds none.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
module etp_probe_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // Emulation processor cycle
   input wire logic cyc_start,
   input wire logic [15:0] cyc_addr,
   input wire logic cyc_fetch,
   input wire logic cyc_wr,
   input wire logic memory_request_strobe,
   input wire logic cpu_rd_n,
   input wire logic [7:0] cpu_wdata,
   input wire logic [7:0] cpu_fetch_byte,
   output logic cpu_wait,
   output logic emul_mem_sel,
   // Target side
   output logic target_rd_n,
   output logic [7:0] tgt_data_o,
   output logic tgt_data_oe_n,
   output logic [7:0] auxiliary_data_header_o,
   output logic auxiliary_data_header_oe_n,
   // Probes and straps
   output logic emulation_active_out,
   output logic event_trigger_n,
   input wire logic map_control_n,
   input wire logic ext_break_n,
   input wire logic [1:0] wait_strap
);
   import etp_pkg::*;

   // Register file state
   logic [3:0] sel_q;
   logic mode1_q;
   logic [16:0] bkpt_q;
   logic [16:0] evpt_q;
   logic [15:0] map_q;
   logic [ETP_IRQ_W-1:0] istat_q, istat_d;
   logic [ETP_IRQ_W-1:0] imask_q;
   etp_state_t state_q, state_d;

   // Two-stage synchronisers for the pins
   logic map_s1_q, map_s2_q;
   logic brk_s1_q, brk_s2_q;
   logic [1:0] strap_s1_q, strap_s2_q;
   logic [1:0] strap_q;
   logic strap_done_q;

   // Cycle capture and timers
   logic [1:0] wait_cnt_q;
   logic [2:0] evt_cnt_q;
   logic [7:0] data_q;
   logic data_en_q;
   logic [7:0] aux_q;
   logic aux_en_q;
   logic interrupt_return_opcode_half_q;

   function automatic logic pt_hit(input logic [16:0] pt, input logic [15:0] a);
      pt_hit = pt[ETP_PT_EN] && (pt[15:0] == a);
   endfunction : pt_hit

   // APB decode; no wait states, unmapped offsets answer with pslverr
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire hit_ctrl = (paddr == ETP_CTRL_OFF);
   wire hit_stat = (paddr == ETP_STAT_OFF);
   wire hit_bkpt = (paddr == ETP_BKPT_OFF);
   wire hit_evpt = (paddr == ETP_EVPT_OFF);
   wire hit_map = (paddr == ETP_MAP_OFF);
   wire hit_istat = (paddr == ETP_ISTAT_OFF);
   wire hit_imask = (paddr == ETP_IMASK_OFF);
   wire mapped = hit_ctrl | hit_stat | hit_bkpt | hit_evpt | hit_map | hit_istat | hit_imask;
   assign pready = 1'b1;
   assign pslverr = acc && !mapped;

   wire go_cmd = wr && hit_ctrl && pwdata[ETP_CTRL_GO];
   wire halt_cmd = wr && hit_ctrl && pwdata[ETP_CTRL_HALT];
   wire running = (state_q == ETP_RUNNING);

   wire map_low = !map_s2_q;
   wire brk_low = !brk_s2_q;

   // Break and event sources, only meaningful while running
   wire fetch_go = cyc_start && cyc_fetch && running;
   wire ext_brk = running && brk_low;
   wire bp_brk = fetch_go && pt_hit(bkpt_q, cyc_addr);
   wire evt_hit = fetch_go && pt_hit(evpt_q, cyc_addr);
   wire any_brk = ext_brk || bp_brk || (running && halt_cmd);

   // Emulation state: a break beats a go in the same cycle
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ETP_HALTED: begin
            if (go_cmd && !brk_low) begin
               state_d = ETP_RUNNING;
            end
         end
         ETP_RUNNING: begin
            if (any_brk) begin
               state_d = ETP_HALTED;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ETP_HALTED;
      end else begin
         state_q <= state_d;
      end
   end

   assign emulation_active_out = running;

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         map_s1_q <= 1'b1;
         map_s2_q <= 1'b1;
         brk_s1_q <= 1'b1;
         brk_s2_q <= 1'b1;
      end else begin
         map_s1_q <= map_control_n;
         map_s2_q <= map_s1_q;
         brk_s1_q <= ext_break_n;
         brk_s2_q <= brk_s1_q;
      end
   end

   // Strap tracks through two flops after reset release and is frozen at the first cycle start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_s1_q <= 2'h0;
         strap_s2_q <= 2'h0;
         strap_q <= ETP_WAIT_DEF;
         strap_done_q <= 1'b0;
      end else begin
         strap_s1_q <= wait_strap;
         strap_s2_q <= strap_s1_q;
         if (!strap_done_q && cyc_start) begin
            strap_q <= (strap_s2_q == 2'h0) ? ETP_WAIT_DEF : strap_s2_q;
            strap_done_q <= 1'b1;
         end else if (!strap_done_q) begin
            strap_q <= (strap_s2_q == 2'h0) ? ETP_WAIT_DEF : strap_s2_q;
         end
      end
   end

   // Control registers written over APB
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_q <= ETP_SEL_RST;
         mode1_q <= ETP_MODE1_RST;
         bkpt_q <= 17'h00000;
         evpt_q <= 17'h00000;
         map_q <= ETP_MAP_RST;
         imask_q <= '0;
      end else if (wr) begin
         if (hit_ctrl) begin
            sel_q <= pwdata[ETP_CTRL_SEL_LSB +: 4];
            mode1_q <= pwdata[ETP_CTRL_MODE1];
         end
         if (hit_bkpt) bkpt_q <= pwdata[16:0];
         if (hit_evpt) evpt_q <= pwdata[16:0];
         if (hit_map) map_q <= pwdata[15:0];
         if (hit_imask) imask_q <= pwdata[ETP_IRQ_W-1:0];
      end
   end

   // Sticky events; a read clears, but a same-cycle event survives
   wire [ETP_IRQ_W-1:0] ev_set = {running && halt_cmd, evt_hit, bp_brk, ext_brk};
   always_comb begin
      istat_d = istat_q;
      if (rd && hit_istat) begin
         istat_d = '0;
      end
      istat_d = istat_d | ev_set;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         istat_q <= '0;
      end else begin
         istat_q <= istat_d;
      end
   end

   assign irq = |(istat_q & imask_q);

   // Read data mux; status shows live block state
   wire sel_bad = sel_q[ETP_SEL_RD_PASS] && sel_q[ETP_SEL_RD_SUPP];
   wire [31:0] stat_word = {26'h0, sel_bad, strap_q, brk_low, map_low, running};
   always_comb begin
      prdata = 32'h00000000;
      if (rd) begin
         unique case (1'b1)
            hit_ctrl: prdata = {25'h0, mode1_q, sel_q, 2'h0};
            hit_stat: prdata = stat_word;
            hit_bkpt: prdata = {15'h0, bkpt_q};
            hit_evpt: prdata = {15'h0, evpt_q};
            hit_map: prdata = {16'h0, map_q};
            hit_istat: prdata = {28'h0, istat_q};
            hit_imask: prdata = {28'h0, imask_q};
            default: prdata = 32'h00000000;
         endcase
      end
   end

   // map control overrides the programmed map
   wire map_emul = map_q[cyc_addr[15:12]];
   assign emul_mem_sel = map_emul && !map_low;

   // read strobe gating from bits 2 and 3
   // normal setting passes strobe regardless of map
   // suppress only for emulation-memory requests in mode one, fetch or not
   wire rd_supp_mode = !sel_q[ETP_SEL_RD_PASS] && sel_q[ETP_SEL_RD_SUPP];
   wire rd_block = rd_supp_mode && mode1_q && emul_mem_sel && memory_request_strobe;
   // prohibited 2+3 setting is flagged in status and treated as pass
   assign target_rd_n = cpu_rd_n || rd_block;

   // wait insertion; counter loaded at each machine cycle start while bit 4 is on
   // bit 4 off means no wait clocks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_cnt_q <= 2'h0;
      end else if (cyc_start && sel_q[ETP_SEL_WAIT]) begin
         wait_cnt_q <= strap_q;
      end else if (wait_cnt_q != 2'h0) begin
         wait_cnt_q <= wait_cnt_q - 2'h1;
      end
   end

   // Wait asserts in the start cycle so the processor sees it in time
   assign cpu_wait = (cyc_start && sel_q[ETP_SEL_WAIT]) || (wait_cnt_q != 2'h0);

   // event trigger held low for a fixed width so scopes catch it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         evt_cnt_q <= 3'h0;
      end else if (evt_hit) begin
         evt_cnt_q <= 3'(ETP_EVT_CYC);
      end else if (evt_cnt_q != 3'h0) begin
         evt_cnt_q <= evt_cnt_q - 3'h1;
      end
   end

   assign event_trigger_n = (evt_cnt_q == 3'h0);

   // data lines gated by select bit 1
   // bit 1 off disconnects the data lines
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_q <= 8'h00;
         data_en_q <= 1'b0;
      end else if (cyc_start) begin
         data_q <= cpu_wdata;
         data_en_q <= sel_q[ETP_SEL_DATA] && cyc_wr && !emul_mem_sel;
      end
   end

   assign tgt_data_o = data_q;
   assign tgt_data_oe_n = !(data_en_q && sel_q[ETP_SEL_DATA]);

   // interrupt-return opcode forced through the auxiliary header
   // Both opcode bytes are driven so buffered peripheral chips see the pair
   // relies on the target qualifying its buffer with memory request
   wire fetch_b0 = cyc_start && cyc_fetch && memory_request_strobe && (cpu_fetch_byte == ETP_INTERRUPT_RETURN_OPCODE_B0);
   wire fetch_b1 = cyc_start && cyc_fetch && memory_request_strobe && (cpu_fetch_byte == ETP_INTERRUPT_RETURN_OPCODE_B1);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_q <= 8'h00;
         aux_en_q <= 1'b0;
         interrupt_return_opcode_half_q <= 1'b0;
      end else if (cyc_start) begin
         interrupt_return_opcode_half_q <= fetch_b0;
         aux_q <= cpu_fetch_byte;
         aux_en_q <= !sel_q[ETP_SEL_DATA] && (fetch_b0 || (interrupt_return_opcode_half_q && fetch_b1));
      end
   end

   assign auxiliary_data_header_o = aux_q;
   assign auxiliary_data_header_oe_n = !aux_en_q;

endmodule : etp_probe_ctrl

//--- etp_probe_ctrl_props.sv
// Port-level property checker for the probe control block
`timescale 1ns/1ps
module etp_chk import etp_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic cyc_start,
   input wire logic cyc_fetch,
   input wire logic cyc_wr,
   input wire logic memory_request_strobe,
   input wire logic cpu_rd_n,
   input wire logic [7:0] cpu_wdata,
   input wire logic [7:0] cpu_fetch_byte,
   input wire logic cpu_wait,
   input wire logic emul_mem_sel,
   input wire logic target_rd_n,
   input wire logic [7:0] tgt_data_o,
   input wire logic tgt_data_oe_n,
   input wire logic [7:0] auxiliary_data_header_o,
   input wire logic auxiliary_data_header_oe_n,
   input wire logic emulation_active_out,
   input wire logic event_trigger_n,
   input wire logic map_control_n,
   input wire logic ext_break_n,
   input wire logic [1:0] wait_strap
);
   logic [4:0] cfg_q;
   wire logic ctrl_wr = psel && penable && pwrite && paddr == ETP_CTRL_OFF;
   // Mirror of select and mode bits, since the checker cannot see inside
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cfg_q <= {ETP_MODE1_RST, ETP_SEL_RST};
      else if (ctrl_wr) cfg_q <= pwdata[6:2];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence evt_low_s; !event_trigger_n [*5]; endsequence
   sequence wait_s; cpu_wait [*4]; endsequence
   // Probe outputs against their causes
   a_go_active: assert property (ctrl_wr && pwdata[ETP_CTRL_GO] && ext_break_n && $past(ext_break_n)
      && $past(ext_break_n, 2) |=> emulation_active_out) else $error("go did not start");
   a_break_halt: assert property ($fell(ext_break_n) && emulation_active_out
      |-> ##[1:3] !emulation_active_out) else $error("break did not halt");
   a_evt_width: assert property ($fell(event_trigger_n) |-> evt_low_s ##1 event_trigger_n)
      else $error("event pulse width wrong");
   a_evt_cause: assert property ($fell(event_trigger_n) |-> $past(cyc_start && cyc_fetch && emulation_active_out))
      else $error("event pulse without fetch");
   a_map_force: assert property (!map_control_n [*3] |-> !emul_mem_sel) else $error("map not forced");
   // Select bit effects
   a_rd_pass: assert property (cfg_q[2:1] == 2'b01 |-> target_rd_n == cpu_rd_n) else $error("strobe not passed");
   a_rd_withhold: assert property (cfg_q[2:1] == 2'b10 && cfg_q[4] && emul_mem_sel && memory_request_strobe
      |-> target_rd_n) else $error("strobe not withheld");
   a_wait_len: assert property (cyc_start && cfg_q[3] && wait_strap == 2'h3 |-> wait_s ##1 !cpu_wait)
      else $error("wait length wrong");
   a_data_gate: assert property (cyc_start && cyc_wr && !emul_mem_sel |=> tgt_data_oe_n != $past(cfg_q[0])
      && (tgt_data_oe_n || tgt_data_o == $past(cpu_wdata))) else $error("data gating wrong");
   a_aux_drive: assert property (cyc_start && cyc_fetch && cpu_fetch_byte == ETP_INTERRUPT_RETURN_OPCODE_B0 && !cfg_q[0]
      |=> !auxiliary_data_header_oe_n && auxiliary_data_header_o == ETP_INTERRUPT_RETURN_OPCODE_B0) else $error("aux not driven");
endmodule : etp_chk
bind etp_probe_ctrl etp_chk u_chk (.*);

//--- etp_tgt_bus.sv
// Behavioural target data bus with a peripheral that watches it
`timescale 1ns/1ps
module etp_tgt_bus (
   input wire logic clk,
   input wire logic memory_request_strobe,
   input wire logic [7:0] tgt_data_o,
   input wire logic tgt_data_oe_n,
   input wire logic [7:0] auxiliary_data_header_o,
   input wire logic auxiliary_data_header_oe_n,
   output logic [7:0] bus_val,
   output logic [7:0] seen_byte
);
   logic [7:0] last_q = 8'h00;
   // No pull-ups here, so a released bus shows the inverse of its last value
   assign bus_val = !auxiliary_data_header_oe_n ? auxiliary_data_header_o : !tgt_data_oe_n ? tgt_data_o : ~last_q;
   // buffer direction qualified
   // Buffer passes only during memory requests; the aux header bypasses it
   always @(posedge clk) begin
      last_q <= bus_val;
      if (!auxiliary_data_header_oe_n || memory_request_strobe) seen_byte <= bus_val;
   end
endmodule : etp_tgt_bus

//--- test_emulator_target_probe_control.sv
// Self-checking bench for the emulator target probe control block
`timescale 1ns/1ps
module test_emulator_target_probe_control;
   import etp_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cyc_start = 1'b0;
   logic cyc_fetch = 1'b0, cyc_wr = 1'b0, memory_request_strobe = 1'b0, cpu_rd_n = 1'b1;
   logic map_control_n = 1'b1, ext_break_n = 1'b1, err;
   logic [7:0] paddr = 8'h00, cpu_wdata = 8'h00, cpu_fetch_byte = 8'h00;
   logic [15:0] cyc_addr = 16'h0000;
   logic [1:0] wait_strap = 2'h3;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, irq, cpu_wait, emul_mem_sel, target_rd_n, tgt_data_oe_n;
   logic auxiliary_data_header_oe_n, emulation_active_out, event_trigger_n;
   logic [7:0] tgt_data_o, auxiliary_data_header_o, bus_val, seen_byte;
   int error_cnt = 0, total_checks = 0;
   etp_probe_ctrl u_dut (.*);
   etp_tgt_bus u_tgt (.*);
   // 25 MHz clock
   initial forever #20 clk = ~clk;
   // One APB transfer, held until pready is seen at an edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   // One machine cycle start pulse with its qualifiers
   task automatic cyc(input logic [15:0] a, input logic f, input logic w, input logic [7:0] b);
      @(posedge clk);
      cyc_start <= 1'b1;
      cyc_addr <= a;
      cyc_fetch <= f;
      cyc_wr <= w;
      cpu_wdata <= b;
      cpu_fetch_byte <= b;
      // A fetch cycle always carries the memory request strobe
      memory_request_strobe <= f;
      @(posedge clk);
      cyc_start <= 1'b0;
      memory_request_strobe <= 1'b0;
      #1;
   endtask : cyc
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic t_regs;
      apb(ETP_CTRL_OFF, 1'b0, 32'h0);
      check("ctrl reset", rd, 32'h4c);
      apb(8'h1c, 1'b0, 32'h0);
      check("unmapped", err, 1'b1);
      check("pready", pready, 1'b1);
      apb(ETP_STAT_OFF, 1'b0, 32'h0);
      check("status", rd, {27'h0, wait_strap, 3'h0});
      $display("regs done");
   endtask : t_regs
   task automatic t_break;
      apb(ETP_IMASK_OFF, 1'b1, 32'h1);
      apb(ETP_CTRL_OFF, 1'b1, 32'h4d);
      check("run", emulation_active_out, 1'b1);
      @(posedge clk);
      ext_break_n <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check("halt", {emulation_active_out, irq}, 2'b01);
      @(posedge clk);
      ext_break_n <= 1'b1;
      apb(ETP_IMASK_OFF, 1'b1, 32'h0);
      check("masked", irq, 1'b0);
      apb(ETP_ISTAT_OFF, 1'b0, 32'h0);
      check("istat", rd[ETP_IRQ_EXT], 1'b1);
      apb(ETP_IMASK_OFF, 1'b1, 32'h1);
      check("cleared", irq, 1'b0);
      $display("break done");
   endtask : t_break
   task automatic t_event;
      apb(ETP_EVPT_OFF, 1'b1, 32'h1_0123);
      apb(ETP_CTRL_OFF, 1'b1, 32'h4d);
      cyc(16'h0123, 1'b1, 1'b0, 8'h00);
      check("evt low", event_trigger_n, 1'b0);
      repeat (ETP_EVT_CYC) @(posedge clk);
      #1;
      check("evt end", event_trigger_n, 1'b1);
      apb(ETP_BKPT_OFF, 1'b1, 32'h1_0124);
      cyc(16'h0124, 1'b1, 1'b0, 8'h00);
      check("bkpt halt", emulation_active_out, 1'b0);
      apb(ETP_CTRL_OFF, 1'b1, 32'h4d);
      check("rerun", emulation_active_out, 1'b1);
      apb(ETP_CTRL_OFF, 1'b1, 32'h4e);
      check("halt cmd", emulation_active_out, 1'b0);
      $display("event done");
   endtask : t_event
   task automatic t_wait;
      int n;
      for (int k = 0; k < 2; k++) begin
         apb(ETP_CTRL_OFF, 1'b1, k ? 32'h4c : 32'h6c);
         cyc(16'h0040, 1'b0, 1'b0, 8'h00);
         n = 0;
         repeat (5) begin
            if (cpu_wait === 1'b1) n++;
            @(posedge clk);
            #1;
         end
         check("waits", n, k ? 32'h0 : {30'h0, wait_strap});
      end
      $display("wait done");
   endtask : t_wait
   task automatic t_data;
      cyc(16'h0040, 1'b0, 1'b1, 8'h5a);
      check("data on", {tgt_data_oe_n, bus_val}, 9'h05a);
      apb(ETP_CTRL_OFF, 1'b1, 32'h48);
      cyc(16'h0040, 1'b0, 1'b1, 8'h5a);
      check("data off", tgt_data_oe_n, 1'b1);
      cyc(16'h0000, 1'b1, 1'b0, ETP_INTERRUPT_RETURN_OPCODE_B0);
      check("aux b0", {auxiliary_data_header_oe_n, bus_val}, {1'b0, ETP_INTERRUPT_RETURN_OPCODE_B0});
      @(posedge clk);
      #1;
      check("seen", seen_byte, ETP_INTERRUPT_RETURN_OPCODE_B0);
      cyc(16'h0001, 1'b1, 1'b0, ETP_INTERRUPT_RETURN_OPCODE_B1);
      check("aux b1", {auxiliary_data_header_oe_n, auxiliary_data_header_o}, {1'b0, ETP_INTERRUPT_RETURN_OPCODE_B1});
      $display("data done");
   endtask : t_data
   task automatic t_map;
      apb(ETP_MAP_OFF, 1'b1, 32'hffff);
      cyc(16'h2000, 1'b0, 1'b0, 8'h00);
      check("emul", emul_mem_sel, 1'b1);
      @(posedge clk);
      map_control_n <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check("forced", emul_mem_sel, 1'b0);
      @(posedge clk);
      map_control_n <= 1'b1;
      memory_request_strobe <= 1'b1;
      cpu_rd_n <= 1'b0;
      // suppress bit set alone, never with pass
      apb(ETP_CTRL_OFF, 1'b1, 32'h54);
      check("rd held", target_rd_n, 1'b1);
      apb(ETP_CTRL_OFF, 1'b1, 32'h4c);
      check("rd pass", target_rd_n, 1'b0);
      $display("map done");
   endtask : t_map
   // Reset for ten cycles, then the scenarios
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_break();
      t_event();
      t_wait();
      t_data();
      t_map();
      report_and_stop();
   end
   // Watchdog, well beyond the hundred or so cycles the run needs
   initial begin
      #100000;
      error_cnt++;
      report_and_stop();
   end
endmodule : test_emulator_target_probe_control
